/* File: verilog/adc_spi_params.svh */
// Constants for the serial frame interface of the converter.
`ifndef ADC_SPI_PARAMS_SVH
`define ADC_SPI_PARAMS_SVH

// ==========================================================================
// Word length selections
`define WL_16 2'h0
`define WL_24 2'h1
`define WL_32_ZERO 2'h2
`define WL_32_SIGN 2'h3
`define WL_RESET `WL_24
`define WBITS_16 6'h10
`define WBITS_24 6'h18
`define WBITS_32 6'h20

// ==========================================================================
// Command words and responses
`define CMD_NULL 16'h0000
`define CMD_RESET 16'h0011
`define CMD_STANDBY 16'h0022
`define CMD_WAKEUP 16'h0033
`define CMD_LOCK 16'h0555
`define CMD_UNLOCK 16'h0655
`define RESP_RESET_DONE 16'hFF23
`define RESP_RESET_SHORT 16'h0011
`define OP_RD_REGS 3'h5
`define OP_WR_REGS 3'h3
`define OP_RD_MULTI_ACK 3'h7
`define OP_WR_ACK 3'h2

// ==========================================================================
// CRC
`define CRC_POLY_CCITT 16'h1021
`define CRC_POLY_ANSI 16'h8005
`define CRC_SEED 16'hFFFF

// ==========================================================================
// Status word bit positions
`define STAT_CRC_ERR_BIT 12
`define STAT_RESULT_READY_BIT 0

// ==========================================================================
// Timing
`define CLK_MHZ 250
`define MCLK_PER_CLK 1
`define TIMEOUT_MCLK 32768
`define TIMEOUT_CYC (`TIMEOUT_MCLK / `MCLK_PER_CLK)
`define READY_PULSE_NS 16
`define READY_PULSE_CYC ((`READY_PULSE_NS * `CLK_MHZ + 999) / 1000)

// ==========================================================================
// Conversion buffer
`define CONV_WIDTH 24
`define CONV_DEPTH 4

`endif

/* File: verilog/adc_spi_pkg.sv */
// Types shared by the serial frame interface.
package adc_spi_pkg;

    // ======================================================================
    // Frame and response selection
    typedef enum logic {FR_IDLE, FR_ACTIVE} frame_t;
    typedef enum logic [1:0] {RS_STATUS, RS_LITERAL, RS_REGISTER} resp_sel_t;

endpackage : adc_spi_pkg

/* File: verilog/crc_bit_step.sv */
// One serial step of a 16-bit CRC, most significant bit first.
module crc_bit_step (
    input wire logic [15:0] crc_in,
    input wire logic data_bit,
    input wire logic [15:0] poly,
    output logic [15:0] crc_out
);
    // ======================================================================
    // Shift with feedback, no reflection and no final inversion.
    always_comb begin
        crc_out = {crc_in[14:0], 1'h0} ^ ((crc_in[15] ^ data_bit) ? poly : 16'h0000);
    end
endmodule : crc_bit_step

/* File: verilog/word_fifo.sv */
// Small word FIFO with valid and ready on both sides.
module word_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] cnt;
        logic not_full;
    } fifo_t;

    fifo_t st;
    fifo_t next_st;
    logic push;
    logic take;

    // ======================================================================
    // Storage and pointers
    always_comb begin
        next_st = st;
        push = in_valid && st.not_full;
        take = out_ready && (st.cnt != '0);
        if (push) begin
            next_st.mem[st.wr] = in_data;
            next_st.wr = (st.wr == AW'(DEPTH - 1)) ? '0 : st.wr + 1'h1;
        end
        if (take) begin
            next_st.rd = (st.rd == AW'(DEPTH - 1)) ? '0 : st.rd + 1'h1;
        end
        next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(take);
        // Ready is held in a flop so the source sees a clean level.
        next_st.not_full = (next_st.cnt != (AW+1)'(DEPTH));
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st <= '0;
            st.not_full <= 1'h1;
        end else begin
            st <= next_st;
        end
    end

    assign in_ready = st.not_full;
    assign out_valid = (st.cnt != '0);
    assign out_data = st.mem[st.rd];
endmodule : word_fifo

/* File: verilog/adc_spi_frame_interface.sv */
// Serial peripheral frame logic of a single-channel delta-sigma converter.
`include "adc_spi_params.svh"

module adc_spi_frame_interface
    import adc_spi_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = `TIMEOUT_CYC
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    output logic dout,
    output logic dout_oe,
    output logic data_ready_n,
    output logic data_ready_n_oe,
    input wire logic [1:0] word_length_sel,
    input wire logic ready_open_drain_sel,
    input wire logic ready_pulse_format_sel,
    input wire logic rx_crc_en,
    input wire logic crc_type_sel,
    input wire logic timeout_en,
    input wire logic adc_enable,
    input wire logic [15:0] status_word,
    input wire logic [23:0] conv_data,
    input wire logic conv_valid,
    output logic conv_ready,
    output logic [5:0] rd_addr,
    input wire logic [15:0] reg_rdata,
    output logic wr_en,
    output logic [5:0] wr_addr,
    output logic [15:0] wr_data,
    output logic cmd_strobe,
    output logic [15:0] cmd_word,
    output logic device_reset_cmd,
    output logic crc_err_flag
);
    typedef struct packed {
        logic cs_s1, cs_s2, cs_d, sclk_s1, sclk_s2, sclk_d, din_s1, din_s2;
        frame_t frm;
        logic [1:0] wsel;
        logic [5:0] out_bit, in_bit;
        logic [7:0] out_word, in_word, wext, rext;
        logic [31:0] out_sr;
        logic dout, dout_oe;
        logic [15:0] in_sr, cmd, in_crc, out_crc;
        logic crc_bad;
        resp_sel_t rsel;
        logic [15:0] resp;
        logic [5:0] rd_addr, wr_addr;
        logic [15:0] wr_data, cmd_word;
        logic wr_en, cmd_strobe, reset_cmd, crc_err, pop;
        logic rdy, brief, unread, rdy_pin, rdy_oe;
        logic [3:0] rdy_cnt;
        logic [15:0] timer;
    } state_t;

    state_t st;
    state_t next_st;

    logic fifo_valid;
    logic fifo_ready;
    logic [23:0] fifo_data;
    logic [15:0] poly;
    logic [15:0] in_crc_step;
    logic [15:0] out_crc_step;
    logic [5:0] wbits;
    logic [7:0] frame_words;
    logic [7:0] conv_idx;
    logic [15:0] stat;
    logic [31:0] tx_word;
    logic tx_bit;
    logic rise;
    logic fall;
    logic cs_rise;
    logic go_idle;
    logic conv_done;
    logic new_res;
    logic complete;
    logic [15:0] w16;

    // ======================================================================
    // Conversion buffer and CRC engines
    word_fifo #(.WIDTH(`CONV_WIDTH), .DEPTH(`CONV_DEPTH)) u_fifo (
        .clk(clk),
        .srst(srst),
        .in_valid(conv_valid),
        .in_ready(fifo_ready),
        .in_data(conv_data),
        .out_valid(fifo_valid),
        .out_ready(st.pop),
        .out_data(fifo_data)
    );

    assign poly = crc_type_sel ? `CRC_POLY_ANSI : `CRC_POLY_CCITT;

    crc_bit_step u_crc_in (
        .crc_in(st.in_crc),
        .data_bit(st.din_s2),
        .poly(poly),
        .crc_out(in_crc_step)
    );

    crc_bit_step u_crc_out (
        .crc_in(st.out_crc),
        .data_bit(tx_bit),
        .poly(poly),
        .crc_out(out_crc_step)
    );

    // ======================================================================
    // Frame geometry
    always_comb begin
        unique case (st.wsel)
            `WL_16: wbits = `WBITS_16;
            `WL_24: wbits = `WBITS_24;
            default: wbits = `WBITS_32;
        endcase
        frame_words = 8'h03 + ((st.wext > st.rext) ? st.wext : st.rext);
        conv_idx = st.rext + 8'h01;
        stat = status_word;
        stat[`STAT_CRC_ERR_BIT] = st.crc_err;
        stat[`STAT_RESULT_READY_BIT] = fifo_valid;
    end

    // ======================================================================
    // Outgoing word selection
    always_comb begin
        tx_word = '0;
        if (st.out_word == 8'h00) begin
            unique case (st.rsel)
                RS_STATUS: tx_word = {stat, 16'h0000};
                RS_LITERAL: tx_word = {st.resp, 16'h0000};
                RS_REGISTER: tx_word = {reg_rdata, 16'h0000};
            endcase
        end else if (st.out_word == frame_words - 8'h01) begin
            tx_word = {st.out_crc, 16'h0000};
        end else if (st.out_word <= st.rext) begin
            tx_word = {reg_rdata, 16'h0000};
        end else if (st.out_word == conv_idx && adc_enable && fifo_valid) begin
            unique case (st.wsel)
                `WL_16: tx_word = {fifo_data[23:8], 16'h0000};
                `WL_32_SIGN: tx_word = {{8{fifo_data[23]}}, fifo_data};
                default: tx_word = {fifo_data, 8'h00};
            endcase
        end
        tx_bit = (st.out_bit == 6'h00) ? tx_word[31] : st.out_sr[31];
    end

    // ======================================================================
    // Next state
    always_comb begin
        next_st = st;
        next_st.wr_en = 1'h0;
        next_st.cmd_strobe = 1'h0;
        next_st.reset_cmd = 1'h0;
        next_st.pop = 1'h0;
        conv_done = 1'h0;
        go_idle = 1'h0;
        complete = 1'h0;
        w16 = {st.in_sr[14:0], st.din_s2};

        // Pins from the host cross in through two flops each.
        next_st.cs_s1 = cs_n;
        next_st.cs_s2 = st.cs_s1;
        next_st.cs_d = st.cs_s2;
        next_st.sclk_s1 = sclk;
        next_st.sclk_s2 = st.sclk_s1;
        next_st.sclk_d = st.sclk_s2;
        next_st.din_s1 = din;
        next_st.din_s2 = st.din_s1;
        rise = st.sclk_s2 && !st.sclk_d;
        fall = !st.sclk_s2 && st.sclk_d;
        cs_rise = st.cs_s2 && !st.cs_d;
        next_st.dout_oe = !st.cs_s2;

        if (st.frm == FR_IDLE) begin
            next_st.wsel = word_length_sel;
        end else begin
            next_st.timer = st.timer + 16'h0001;
            // A stuck select line cannot hang the interface forever.
            if (timeout_en && st.timer >= 16'(TIMEOUT_CYCLES - 1)) begin
                go_idle = 1'h1;
            end
        end

        // Transmit side.
        if (!st.cs_s2 && rise) begin
            if (st.frm == FR_IDLE) begin
                next_st.frm = FR_ACTIVE;
                next_st.timer = 16'h0000;
            end
            next_st.dout = tx_bit;
            next_st.out_sr = (st.out_bit == 6'h00) ? {tx_word[30:0], 1'h0}
                                                   : {st.out_sr[30:0], 1'h0};
            if (st.out_word != frame_words - 8'h01) begin
                next_st.out_crc = out_crc_step;
            end
            if (st.out_bit == 6'h00) begin
                if (st.out_word == 8'h00 && st.rsel == RS_STATUS) begin
                    next_st.crc_err = 1'h0;
                end
                if (st.out_word != 8'h00 && st.out_word <= st.rext) begin
                    next_st.rd_addr = st.rd_addr + 6'h01;
                end
                if (st.out_word == conv_idx) begin
                    next_st.pop = fifo_valid && adc_enable;
                    next_st.unread = 1'h0;
                end
            end
            if (st.out_bit == wbits - 6'h01) begin
                next_st.out_bit = 6'h00;
                next_st.out_word = st.out_word + 8'h01;
                conv_done = (st.out_word == conv_idx);
            end else begin
                next_st.out_bit = st.out_bit + 6'h01;
            end
        end

        // Receive side.
        if (!st.cs_s2 && fall && st.frm == FR_ACTIVE) begin
            next_st.in_sr = w16;
            if (st.in_word < st.wext + 8'h01) begin
                next_st.in_crc = in_crc_step;
            end
            if (st.in_bit == 6'h0F) begin
                if (st.in_word == 8'h00) begin
                    next_st.cmd = w16;
                    if (w16[15:13] == `OP_WR_REGS) begin
                        next_st.wext = {1'h0, w16[6:0]} + 8'h01;
                    end
                end else if (st.in_word <= st.wext) begin
                    // Writes go out as received, so they stand even on a bad CRC.
                    next_st.wr_en = 1'h1;
                    next_st.wr_addr = st.cmd[12:7] + 6'(st.in_word - 8'h01);
                    next_st.wr_data = w16;
                end else if (st.in_word == st.wext + 8'h01) begin
                    next_st.crc_bad = rx_crc_en && (w16 != st.in_crc);
                end
            end
            if (st.in_bit == wbits - 6'h01) begin
                next_st.in_bit = 6'h00;
                next_st.in_word = st.in_word + 8'h01;
            end else begin
                next_st.in_bit = st.in_bit + 6'h01;
            end
        end

        // Command decode at the end of the frame.
        if (cs_rise && st.frm == FR_ACTIVE) begin
            go_idle = 1'h1;
            complete = (st.in_word >= frame_words);
            next_st.rsel = RS_LITERAL;
            next_st.rext = 8'h00;
            if (st.crc_bad) begin
                next_st.crc_err = 1'h1;
                next_st.rsel = RS_STATUS;
            end else if (st.cmd == `CMD_RESET) begin
                next_st.reset_cmd = complete;
                next_st.resp = complete ? `RESP_RESET_DONE : `RESP_RESET_SHORT;
            end else if (st.cmd[15:13] == `OP_RD_REGS) begin
                next_st.rd_addr = st.cmd[12:7];
                if (st.cmd[6:0] == 7'h00) begin
                    next_st.rsel = RS_REGISTER;
                end else begin
                    next_st.resp = {`OP_RD_MULTI_ACK, st.cmd[12:0]};
                    next_st.rext = {1'h0, st.cmd[6:0]} + 8'h01;
                end
            end else if (st.cmd[15:13] == `OP_WR_REGS) begin
                next_st.resp = {`OP_WR_ACK, st.cmd[12:0]};
            end else if (st.cmd == `CMD_STANDBY || st.cmd == `CMD_WAKEUP ||
                         st.cmd == `CMD_LOCK || st.cmd == `CMD_UNLOCK) begin
                next_st.resp = st.cmd;
                next_st.cmd_word = st.cmd;
                next_st.cmd_strobe = complete;
            end else begin
                next_st.rsel = RS_STATUS;
            end
        end

        if (go_idle) begin
            next_st.frm = FR_IDLE;
            next_st.out_bit = 6'h00;
            next_st.out_word = 8'h00;
            next_st.in_bit = 6'h00;
            next_st.in_word = 8'h00;
            next_st.wext = 8'h00;
            next_st.cmd = `CMD_NULL;
            next_st.crc_bad = 1'h0;
            next_st.in_crc = `CRC_SEED;
            next_st.out_crc = `CRC_SEED;
            next_st.timer = 16'h0000;
        end

        // Data ready generation.
        new_res = conv_valid && fifo_ready;
        if (st.brief) begin
            next_st.brief = 1'h0;
            next_st.rdy = 1'h0;
        end
        if (st.rdy_cnt != 4'h0) begin
            next_st.rdy_cnt = st.rdy_cnt - 4'h1;
            if (st.rdy_cnt == 4'h1) begin
                next_st.rdy = 1'h1;
            end
        end
        if (conv_done && !ready_pulse_format_sel) begin
            next_st.rdy = 1'h1;
        end
        if (new_res) begin
            if (!ready_pulse_format_sel) begin
                // A still-low line goes high for one cycle so the host sees an edge.
                if (!st.rdy) begin
                    next_st.rdy = 1'h1;
                    next_st.brief = 1'h1;
                end else begin
                    next_st.rdy = 1'h0;
                end
            end else if (st.unread) begin
                next_st.unread = 1'h0;
            end else begin
                next_st.rdy = 1'h0;
                next_st.rdy_cnt = 4'(`READY_PULSE_CYC);
                next_st.unread = 1'h1;
            end
        end
        next_st.rdy_pin = ready_open_drain_sel ? 1'h0 : next_st.rdy;
        next_st.rdy_oe = ready_open_drain_sel ? !next_st.rdy : 1'h1;
    end

    // ======================================================================
    // State register
    always_ff @(posedge clk) begin
        if (srst) begin
            st <= '0;
            st.cs_s1 <= 1'h1;
            st.cs_s2 <= 1'h1;
            st.cs_d <= 1'h1;
            st.frm <= FR_IDLE;
            st.wsel <= `WL_RESET;
            st.rsel <= RS_STATUS;
            st.in_crc <= `CRC_SEED;
            st.out_crc <= `CRC_SEED;
            st.rdy <= 1'h1;
            st.rdy_pin <= 1'h1;
            st.rdy_oe <= 1'h1;
        end else begin
            st <= next_st;
        end
    end

    assign dout = st.dout;
    assign dout_oe = st.dout_oe;
    assign data_ready_n = st.rdy_pin;
    assign data_ready_n_oe = st.rdy_oe;
    assign conv_ready = fifo_ready;
    assign rd_addr = st.rd_addr;
    assign wr_en = st.wr_en;
    assign wr_addr = st.wr_addr;
    assign wr_data = st.wr_data;
    assign cmd_strobe = st.cmd_strobe;
    assign cmd_word = st.cmd_word;
    assign device_reset_cmd = st.reset_cmd;
    assign crc_err_flag = st.crc_err;
endmodule : adc_spi_frame_interface

/* File: tb/adc_spi_frame_interface_monitor.sv */
// Concurrent checks on the pins of the serial frame interface.
module adc_spi_frame_monitor
    import adc_spi_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = 64
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic dout,
    input wire logic dout_oe,
    input wire logic data_ready_n,
    input wire logic data_ready_n_oe,
    input wire logic ready_open_drain_sel,
    input wire logic ready_pulse_format_sel,
    input wire logic device_reset_cmd,
    input wire logic cmd_strobe
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking mon_cb @(posedge clk);
    endclocking
    default disable iff (srst);

    // ======================================================================
    // Assertions
    dout_off_a: assert property (cs_n [*8] |-> !dout_oe)
        else $error("dout driven while deselected");
    // Output bits may only move a few cycles after a serial clock rise.
    dout_launch_a: assert property (!cs_n && !$past(cs_n, 8) && dout_oe && $changed(dout)
        |-> $past(sclk, 3) || $past(sclk, 4) || $past(sclk, 5))
        else $error("dout changed away from a serial clock rise");
    push_pull_a: assert property (!ready_open_drain_sel && !$past(ready_open_drain_sel)
        |-> data_ready_n_oe)
        else $error("ready not driven in push-pull mode");
    open_drain_a: assert property (ready_open_drain_sel && $past(ready_open_drain_sel)
        && data_ready_n_oe |-> !data_ready_n)
        else $error("ready driven high in open-drain mode");
    ready_pulse_a: assert property (ready_pulse_format_sel && !ready_open_drain_sel
        && $fell(data_ready_n) |-> !data_ready_n [*4] ##1 data_ready_n)
        else $error("ready pulse has wrong length");
    reset_pulse_a: assert property (device_reset_cmd |=> !device_reset_cmd)
        else $error("reset strobe longer than one cycle");
    reset_deselect_a: assert property (device_reset_cmd |-> cs_n && $past(cs_n, 3) && !sclk)
        else $error("reset strobe inside a frame");
    cmd_deselect_a: assert property (cmd_strobe |-> cs_n && $past(cs_n, 3))
        else $error("command strobe inside a frame");

    // ======================================================================
    // Coverage
    cover property ($fell(data_ready_n));
    cover property (device_reset_cmd);
    cover property ($rose(dout_oe));
endmodule : adc_spi_frame_monitor

bind adc_spi_frame_interface adc_spi_frame_monitor #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_monitor (
    .clk(clk), .srst(srst), .sclk(sclk), .cs_n(cs_n), .dout(dout), .dout_oe(dout_oe),
    .data_ready_n(data_ready_n), .data_ready_n_oe(data_ready_n_oe),
    .ready_open_drain_sel(ready_open_drain_sel), .ready_pulse_format_sel(ready_pulse_format_sel),
    .device_reset_cmd(device_reset_cmd), .cmd_strobe(cmd_strobe));

/* File: tb/spi_host_model.sv */
// Host controller model that runs mode 1 frames.
module spi_host_model
    import adc_spi_pkg::*;
(
    output logic sclk,
    output logic cs_n,
    output logic din,
    input wire logic dout,
    input wire logic dout_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [31:0] tx [0:7];
    logic [31:0] rx [0:7];

    initial begin
        sclk = 1'h0;
        cs_n = 1'h1;
        din = 1'h0;
    end

    // The serial clock stands still between frames, so no edge is seen outside one.
    task automatic frame(input int n, input int wb);
        #0.7 cs_n = 1'h0;
        #80;
        for (int w = 0; w < n; w++) begin
            rx[w] = 32'h0;
            for (int b = wb - 1; b >= 0; b--) begin
                sclk = 1'h1;
                din = tx[w][b];
                #80;
                sclk = 1'h0;
                rx[w] = {rx[w][30:0], dout_oe ? dout : ~rx[w][0]};
                #80;
            end
        end
        cs_n = 1'h1;
        din = ~din;
        #400;
    endtask : frame
endmodule : spi_host_model

/* File: tb/adc_spi_frame_interface_test.sv */
// Self-checking bench of the serial frame interface.
`include "adc_spi_params.svh"
`define CHK(what, e, g) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
    $display("Error %s expected %h seen %h", what, e, g); end end

module adc_spi_frame_interface_test
    import adc_spi_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'h0;
    logic srst, sclk, cs_n, din, dout, dout_oe, data_ready_n, data_ready_n_oe;
    logic ready_open_drain_sel, ready_pulse_format_sel, rx_crc_en, crc_type_sel;
    logic timeout_en, adc_enable, conv_valid, conv_ready, cmd_strobe, device_reset_cmd;
    logic crc_err_flag, wr_en;
    logic [1:0] word_length_sel;
    logic [15:0] status_word, reg_rdata, cmd_word, bad, wr_data;
    logic [23:0] conv_data;
    logic [5:0] rd_addr, wr_addr;
    logic [21:0] wr_last;
    int miscompares = 0;
    int samples_checked = 0;
    int reset_seen = 0;
    int cmd_seen = 0;
    int ready_falls = 0;
    localparam logic [15:0] STAT = 16'h0A50;
    logic [31:0] conv_exp [0:3] = '{32'h8765, 32'h876543, 32'h87654300, 32'hFF876543};
    int wbits [0:3] = '{16, 24, 32, 32};
    // The ready line has a pull-up, so a released line reads high.
    wire ready_pin = data_ready_n_oe ? data_ready_n : 1'h1;
    assign reg_rdata = {10'h000, rd_addr};
    always @(negedge ready_pin) ready_falls++;
    always @(posedge clk) if (wr_en === 1'h1) wr_last <= {wr_addr, wr_data};

    always #2 clk = ~clk;

    always @(posedge clk) begin
        if (device_reset_cmd === 1'h1) reset_seen++;
        if (cmd_strobe === 1'h1 && cmd_word === `CMD_STANDBY) cmd_seen++;
    end

    adc_spi_frame_interface #(.TIMEOUT_CYCLES(64)) u_dut (
        .clk(clk), .srst(srst), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
        .dout_oe(dout_oe), .data_ready_n(data_ready_n), .data_ready_n_oe(data_ready_n_oe),
        .word_length_sel(word_length_sel), .ready_open_drain_sel(ready_open_drain_sel),
        .ready_pulse_format_sel(ready_pulse_format_sel), .rx_crc_en(rx_crc_en),
        .crc_type_sel(crc_type_sel), .timeout_en(timeout_en), .adc_enable(adc_enable),
        .status_word(status_word), .conv_data(conv_data), .conv_valid(conv_valid),
        .conv_ready(conv_ready), .rd_addr(rd_addr), .reg_rdata(reg_rdata), .wr_en(wr_en),
        .wr_addr(wr_addr), .wr_data(wr_data), .cmd_strobe(cmd_strobe), .cmd_word(cmd_word),
        .device_reset_cmd(device_reset_cmd), .crc_err_flag(crc_err_flag));

    spi_host_model u_host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout), .dout_oe(dout_oe));

    // ======================================================================
    // Helpers
    function automatic logic [15:0] crc_add(logic [15:0] c, logic [31:0] w, int n, logic [15:0] p);
        for (int i = n - 1; i >= 0; i--) c = {c[14:0], 1'h0} ^ ((c[15] ^ w[i]) ? p : 16'h0);
        return c;
    endfunction : crc_add

    task automatic push(input logic [23:0] d);
        @(negedge clk);
        conv_data = d;
        conv_valid = 1'h1;
        do @(posedge clk); while (conv_ready !== 1'h1);
        @(negedge clk);
        conv_valid = 1'h0;
        repeat (10) @(negedge clk);
    endtask : push

    task automatic run(input int n, input int wb, input logic [15:0] cmd, input logic [31:0] w1);
        logic [15:0] c;
        c = `CRC_SEED;
        u_host.tx[0] = 32'(cmd) << (wb - 16);
        for (int i = 1; i < 8; i++) u_host.tx[i] = (i == 1) ? w1 : 32'h0;
        u_host.frame(n, wb);
        if (n > 2) begin
            for (int i = 0; i < n - 1; i++)
                c = crc_add(c, u_host.rx[i], wb, crc_type_sel ? `CRC_POLY_ANSI : `CRC_POLY_CCITT);
            `CHK("output crc", 32'(c) << (wb - 16), u_host.rx[n - 1])
        end
        @(negedge clk);
    endtask : run

    task automatic test_done();
        if (miscompares == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : test_done

    // ======================================================================
    // Tests
    initial begin
        srst = 1'h1;
        word_length_sel = 2'h1;
        {ready_open_drain_sel, ready_pulse_format_sel, rx_crc_en, crc_type_sel} = 4'h0;
        timeout_en = 1'h0;
        adc_enable = 1'h1;
        status_word = STAT;
        conv_data = 24'h0;
        conv_valid = 1'h0;
        repeat (5) @(posedge clk);
        @(negedge clk);
        srst = 1'h0;
        repeat (8) @(negedge clk);
        `CHK("dout_oe idle", 1'h0, dout_oe)
        `CHK("ready idle", 1'h1, ready_pin)
        for (int m = 0; m < 4; m++) begin
            word_length_sel = m[1:0];
            crc_type_sel = m[0];
            push(24'h876543);
            `CHK("ready low", 1'h0, ready_pin)
            run(3, wbits[m], `CMD_NULL, 32'h0);
            `CHK("status resp", 32'(STAT | 16'h1) << (wbits[m] - 16), u_host.rx[0])
            `CHK("conversion", conv_exp[m], u_host.rx[1])
            `CHK("ready high", 1'h1, ready_pin)
        end
        word_length_sel = 2'h1;
        crc_type_sel = 1'h0;
        adc_enable = 1'h0;
        run(3, 24, `CMD_RESET, 32'h0);
        `CHK("empty status", {8'h00, STAT, 8'h00}, u_host.rx[0])
        `CHK("zero conversion", 32'h0, u_host.rx[1])
        `CHK("reset pulses", 1, reset_seen)
        run(1, 24, `CMD_RESET, 32'h0);
        `CHK("reset ack", {8'h00, `RESP_RESET_DONE, 8'h00}, u_host.rx[0])
        `CHK("short reset", 1, reset_seen)
        run(1, 24, `CMD_NULL, 32'h0);
        `CHK("short reset resp", {8'h00, `RESP_RESET_SHORT, 8'h00}, u_host.rx[0])
        rx_crc_en = 1'h1;
        bad = ~crc_add(`CRC_SEED, 32'h0, 24, `CRC_POLY_CCITT);
        run(3, 24, `CMD_NULL, {8'h00, bad, 8'h00});
        `CHK("crc error flag", 1'h1, crc_err_flag)
        rx_crc_en = 1'h0;
        run(3, 24, `CMD_STANDBY, 32'h0);
        `CHK("error status", {8'h00, STAT | 16'h1000, 8'h00}, u_host.rx[0])
        `CHK("flag cleared", 1'h0, crc_err_flag)
        `CHK("standby taken", 1, cmd_seen)
        run(4, 24, 16'h6180, 32'h005A3C00);
        `CHK("register write", {6'h03, 16'h5A3C}, wr_last)
        run(3, 24, 16'hA281, 32'h0);
        `CHK("write ack", {8'h00, 16'h4180, 8'h00}, u_host.rx[0])
        run(5, 24, `CMD_NULL, 32'h0);
        `CHK("read ack", {8'h00, 16'hE281, 8'h00}, u_host.rx[0])
        `CHK("first register", 32'h00000500, u_host.rx[1])
        `CHK("second register", 32'h00000600, u_host.rx[2])
        // A frame far longer than the timeout is cut into fragments, so its command never lands.
        timeout_en = 1'h1;
        u_host.tx[0] = 32'(`CMD_STANDBY) << 8;
        u_host.frame(3, 24);
        @(negedge clk);
        timeout_en = 1'h0;
        `CHK("timeout drops command", 1, cmd_seen)
        ready_pulse_format_sel = 1'h1;
        adc_enable = 1'h1;
        push(24'h123456);
        `CHK("pulse ended", 1'h1, ready_pin)
        push(24'h654321);
        `CHK("skipped pulse", 5, ready_falls)
        ready_open_drain_sel = 1'h1;
        repeat (4) @(negedge clk);
        `CHK("ready released", 1'h0, data_ready_n_oe)
        `CHK("pulled high", 1'h1, ready_pin)
        test_done();
    end

    // A hung handshake or frame would otherwise stall the run forever.
    initial begin
        #300000;
        miscompares++;
        test_done();
    end
endmodule : adc_spi_frame_interface_test
